// file: verilog/fpac_pkg.sv
// Shared constants, mode codes and the configuration register table
// for the front-panel amplitude and configuration block.
// Assumes a 100 MHz system clock; nothing is imported, all uses are scoped.
`default_nettype none
package fpac_pkg;
  // Clock rate and key timing, times in ms, counts derived from them
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned REPEAT_MS  = 250;
  localparam int unsigned HOLD_MS    = 4000;
  localparam int unsigned REPEAT_CYC = (CLK_HZ / 1000) * REPEAT_MS;
  localparam int unsigned HOLD_CYC   = (CLK_HZ / 1000) * HOLD_MS;

  // Step sizes for the arrow keys
  localparam logic [15:0] STEP_FINE   = 16'h0001;
  localparam logic [15:0] STEP_COARSE = 16'h0005;

  // Amplitude setpoint limits and reset value, in percent
  localparam logic [15:0] AMP_MIN = 16'h000a;
  localparam logic [15:0] AMP_MAX = 16'h0064;
  localparam logic [7:0]  AMP_RST = 8'h64;

  // Configuration register numbering
  localparam logic [7:0] REG_FIRST    = 8'h65;  // Register 101
  localparam logic [7:0] REG_LAST     = 8'ha3;  // Register 163
  localparam int         REG_CNT      = 63;
  localparam logic [7:0] REG_EXTAMP   = 8'h68;  // Register 104
  localparam logic [7:0] REG_PWRON    = 8'h88;  // Register 136
  localparam logic [7:0] REG_WELDMODE = 8'h8a;  // Register 138

  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_AMP    = 8'h08;
  localparam logic [7:0] OFS_SEL    = 8'h0c;
  localparam logic [7:0] OFS_DATA   = 8'h10;
  localparam logic [7:0] OFS_DISP   = 8'h14;

  // Control register fields and reset value
  localparam int         CTRL_POLICY_BIT = 0;
  localparam int         CTRL_ANASEL_BIT = 1;
  localparam logic [1:0] CTRL_RST        = 2'h1;

  // Front-panel modes, one-hot
  typedef enum logic [3:0] {
    FPAC_AMP    = 4'h1,
    FPAC_WELD   = 4'h2,
    FPAC_BROWSE = 4'h4,
    FPAC_EDIT   = 4'h8
  } fpac_mode_t;

  // Default, maximum and minimum of a register, packed {def, max, min}
  function automatic logic [47:0] fpac_reg_lim(input logic [7:0] num);
    case (num)
      8'h66, 8'h68, 8'h6d, 8'h6f, 8'h71, 8'h72: return {16'h0000, 16'h0001, 16'h0000};
      8'h69, 8'h6c: return {16'h0050, 16'h03e8, 16'h000a};
      8'h6a: return {16'h0001, 16'h0001, 16'h0000};
      8'h6b: return {16'h0001, 16'h0002, 16'h0000};
      8'h6e: return {16'h01f4, 16'h03e8, 16'h000a};
      8'h73: return {16'h0000, 16'h0002, 16'h0000};
      8'h86: return {16'h0258, 16'h270f, 16'h0000};
      8'h87: return {16'h0005, 16'h0032, 16'h0001};
      8'h88: return {16'h0001, 16'h0001, 16'h0000};
      8'h8a: return {16'h0000, 16'h0004, 16'h0000};
      8'ha2, 8'ha3: return {16'h0000, 16'h0064, 16'h0000};
      default: return {16'h0000, 16'h0000, 16'h0000};
    endcase
  endfunction
endpackage
`default_nettype wire

// file: verilog/fpac_top.sv
// Front-panel control of the welding supply: amplitude keys with
// auto-repeat, external amplitude, overload alarm, register browse/edit.
// Assumes key and user I/O pins are asynchronous, APB on the system clock.
`timescale 1ns/1ns
`default_nettype none
module fpac_top #(
  parameter int unsigned REPEAT_CYC = fpac_pkg::REPEAT_CYC,
  parameter int unsigned HOLD_CYC   = fpac_pkg::HOLD_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Front-panel keys, high while pressed
  input  wire logic        key_up,
  input  wire logic        key_down,
  input  wire logic        key_cfg,
  input  wire logic        key_rst,
  // User I/O lines
  input  wire logic        ext_reset_in,
  input  wire logic        start_in,
  input  wire logic        overload_in,
  input  wire logic [7:0]  ana_in_a,
  input  wire logic [7:0]  ana_in_b,
  output logic             alarm_out,
  output logic      [7:0]  amp_setpoint,
  // LCD contents
  output logic      [15:0] disp_value,
  output logic             disp_dashes,
  output logic             icon_pct,
  output logic             icon_num,
  output logic             icon_circle,
  output logic             icon_alarm,
  output logic             icon_mode
);

  // Pin synchronisers: up, down, cfg, reset key, external reset, start
  logic [5:0] pin_raw;                 // Raw pin levels
  logic [5:0] meta_ff;                 // First stage, read only by sync_ff
  logic [5:0] sync_ff;                 // Second stage
  logic [5:0] prev_ff;                 // Last synchronised level
  logic [5:0] rise;                    // Press edges
  assign pin_raw = {start_in, ext_reset_in, key_rst, key_cfg, key_down, key_up};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      // Two flops per pin, then an edge reference; start resets to its
      // idle high level so that no false edge follows reset
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          meta_ff[gi] <= (gi == 5);
          sync_ff[gi] <= (gi == 5);
          prev_ff[gi] <= (gi == 5);
        end else begin
          meta_ff[gi] <= pin_raw[gi];
          sync_ff[gi] <= meta_ff[gi];
          prev_ff[gi] <= sync_ff[gi];
        end
      end
      assign rise[gi] = sync_ff[gi] & ~prev_ff[gi];
    end
  endgenerate

  // Named key levels and edges
  wire up_s      = sync_ff[0];
  wire cfg_press = rise[2];
  wire rst_press = rise[3];
  wire extrst_s  = sync_ff[4];
  wire start_up  = rise[5];

  // Arrow key timing
  logic        held_prev_ff;           // Arrow held last cycle
  logic [31:0] rep_cnt_ff;             // Quarter-second repeat counter
  logic [31:0] hold_cnt_ff;            // Four-second hold counter, saturating
  wire  arrow_held = sync_ff[0] | sync_ff[1];
  wire  press      = arrow_held & ~held_prev_ff;
  wire  rep_wrap   = rep_cnt_ff == REPEAT_CYC - 1;
  wire  rep_tick   = arrow_held & ~press & rep_wrap;
  wire  coarse     = hold_cnt_ff == HOLD_CYC;
  wire  step_ev    = press | rep_tick;
  wire  [15:0] step_sz = (rep_tick & coarse) ? fpac_pkg::STEP_COARSE : fpac_pkg::STEP_FINE;

  // Repeat tick and hold timer, both cleared on release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      held_prev_ff <= 1'b0;
      rep_cnt_ff   <= 32'h0;
      hold_cnt_ff  <= 32'h0;
    end else begin
      held_prev_ff <= arrow_held;
      if (!arrow_held || press || rep_wrap) begin
        rep_cnt_ff <= 32'h0;
      end else begin
        rep_cnt_ff <= rep_cnt_ff + 32'h1;
      end
      if (!arrow_held) begin
        hold_cnt_ff <= 32'h0;
      end else if (!coarse) begin
        hold_cnt_ff <= hold_cnt_ff + 32'h1;
      end
    end
  end

  // Step a value up or down and keep it inside [lo, hi]
  function automatic logic [15:0] step_clamp(input logic [15:0] v, input logic [15:0] sz,
                                             input logic up, input logic [15:0] lo,
                                             input logic [15:0] hi);
    logic [16:0] sum;
    logic [16:0] floor_v;
    sum     = {1'b0, v} + {1'b0, sz};
    floor_v = {1'b0, lo} + {1'b0, sz};
    if (up) begin
      return (sum > {1'b0, hi}) ? hi : sum[15:0];
    end
    return ({1'b0, v} < floor_v) ? lo : v - sz;
  endfunction

  // Default value of a register, the top field of its limit entry
  function automatic logic [15:0] reg_def(input logic [7:0] num);
    logic [47:0] ent;
    ent = fpac_pkg::fpac_reg_lim(num);
    return ent[47:32];
  endfunction

  // Software control and selection registers, then front-panel state
  logic [1:0]  ctrl_ff;                // Alarm policy, analog input select
  logic [7:0]  sel_ff;                 // Register number seen through OFS_DATA
  logic [7:0]  amp_ff;                 // Panel amplitude setpoint
  logic        alarm_ff;               // Overload alarm
  logic [7:0]  reg_num_ff;             // Browsed register number
  logic [15:0] edit_val_ff;            // Value under edit
  logic        init_ff;                // Power-up display choice made
  fpac_pkg::fpac_mode_t mode_ff;       // Front-panel mode
  logic [15:0] cfg_mem [fpac_pkg::REG_CNT];  // Configuration register values

  // APB decode
  wire apb_wr    = psel & penable & pwrite;
  wire hit_ctrl  = paddr == fpac_pkg::OFS_CTRL;
  wire hit_stat  = paddr == fpac_pkg::OFS_STATUS;
  wire hit_amp   = paddr == fpac_pkg::OFS_AMP;
  wire hit_sel   = paddr == fpac_pkg::OFS_SEL;
  wire hit_data  = paddr == fpac_pkg::OFS_DATA;
  wire hit_disp  = paddr == fpac_pkg::OFS_DISP;
  wire mapped    = hit_ctrl | hit_stat | hit_amp | hit_sel | hit_data | hit_disp;
  wire sel_ok    = sel_ff >= fpac_pkg::REG_FIRST && sel_ff <= fpac_pkg::REG_LAST;
  wire [7:0] sel_off = sel_ff - fpac_pkg::REG_FIRST;
  wire [5:0] sel_idx = sel_off[5:0];
  wire [7:0] num_off = reg_num_ff - fpac_pkg::REG_FIRST;
  wire [5:0] num_idx = num_off[5:0];

  // Values that steer the panel
  localparam logic [7:0] EXT_OFF  = fpac_pkg::REG_EXTAMP - fpac_pkg::REG_FIRST;
  localparam logic [7:0] PWR_OFF  = fpac_pkg::REG_PWRON - fpac_pkg::REG_FIRST;
  localparam logic [7:0] WELD_OFF = fpac_pkg::REG_WELDMODE - fpac_pkg::REG_FIRST;
  wire        ext_on   = cfg_mem[EXT_OFF[5:0]] != 16'h0;
  wire [15:0] weld_val = cfg_mem[WELD_OFF[5:0]];
  wire [47:0] lim      = fpac_pkg::fpac_reg_lim(reg_num_ff);
  wire [15:0] lim_def  = lim[47:32];
  wire [15:0] lim_max  = lim[31:16];
  wire [15:0] lim_min  = lim[15:0];
  wire        in_amp   = mode_ff == fpac_pkg::FPAC_AMP;
  wire        in_brw   = mode_ff == fpac_pkg::FPAC_BROWSE;
  wire        in_edit  = mode_ff == fpac_pkg::FPAC_EDIT;
  wire        commit   = in_edit & cfg_press;
  // Weld mode after a commit, counting a commit to the weld mode register
  wire [15:0] weld_new = (reg_num_ff == fpac_pkg::REG_WELDMODE) ? edit_val_ff : weld_val;
  wire [15:0] amp_step = step_clamp({8'h0, amp_ff}, step_sz, up_s,
                                    fpac_pkg::AMP_MIN, fpac_pkg::AMP_MAX);
  wire [15:0] amp_wr   = (pwdata[15:0] > fpac_pkg::AMP_MAX) ? fpac_pkg::AMP_MAX :
                         (pwdata[15:0] < fpac_pkg::AMP_MIN) ? fpac_pkg::AMP_MIN : pwdata[15:0];

  // Front-panel mode sequence
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_ff <= fpac_pkg::FPAC_AMP;
      init_ff <= 1'b0;
    end else if (!init_ff) begin
      init_ff <= 1'b1;
      // Power-on display option picks weld mode or amplitude
      mode_ff <= (cfg_mem[PWR_OFF[5:0]] == 16'h0) ? fpac_pkg::FPAC_WELD
                                                  : fpac_pkg::FPAC_AMP;
    end else if (cfg_press) begin
      unique case (mode_ff)
        fpac_pkg::FPAC_AMP:    mode_ff <= fpac_pkg::FPAC_BROWSE;
        fpac_pkg::FPAC_WELD:   mode_ff <= fpac_pkg::FPAC_AMP;
        fpac_pkg::FPAC_BROWSE: mode_ff <= fpac_pkg::FPAC_EDIT;
        fpac_pkg::FPAC_EDIT: begin
          // Continuous weld shows amplitude, else the weld mode view
          mode_ff <= (weld_new == 16'h0) ? fpac_pkg::FPAC_AMP : fpac_pkg::FPAC_WELD;
        end
        default:               mode_ff <= fpac_pkg::FPAC_AMP;
      endcase
    end
  end

  // Amplitude setpoint, panel keys or software
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      amp_ff <= fpac_pkg::AMP_RST;
    end else if (in_amp && step_ev && !ext_on) begin
      amp_ff <= amp_step[7:0];
    end else if (apb_wr && hit_amp) begin
      amp_ff <= amp_wr[7:0];
    end
  end

  // Register number under browse, starts at the first register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_num_ff <= fpac_pkg::REG_FIRST;
    end else if (in_brw && press) begin
      if (up_s) begin
        reg_num_ff <= (reg_num_ff == fpac_pkg::REG_LAST) ? reg_num_ff
                                                         : reg_num_ff + 8'h1;
      end else begin
        reg_num_ff <= (reg_num_ff == fpac_pkg::REG_FIRST) ? reg_num_ff
                                                          : reg_num_ff - 8'h1;
      end
    end
  end

  // Edit buffer: loaded on entry, stepped, or set to default
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      edit_val_ff <= 16'h0;
    end else if (in_brw && cfg_press) begin
      edit_val_ff <= cfg_mem[num_idx];
    end else if (in_edit && rst_press) begin
      edit_val_ff <= lim_def;
    end else if (in_edit && step_ev) begin
      edit_val_ff <= step_clamp(edit_val_ff, step_sz, up_s, lim_min, lim_max);
    end
  end

  // Configuration registers: panel commit wins over a software write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < fpac_pkg::REG_CNT; i++) begin
        cfg_mem[i] <= reg_def(fpac_pkg::REG_FIRST + 8'(i));
      end
    end else if (commit) begin
      cfg_mem[num_idx] <= edit_val_ff;
    end else if (apb_wr && hit_data && sel_ok) begin
      cfg_mem[sel_idx] <= pwdata[15:0];
    end
  end

  // Alarm clear sources by policy
  wire policy_rr = ctrl_ff[fpac_pkg::CTRL_POLICY_BIT];
  wire clr_rr    = policy_rr & ((rst_press & ~in_edit) | extrst_s);
  wire clr_nr    = ~policy_rr & start_up;
  wire alarm_clr = clr_rr | clr_nr;

  // Overload alarm, a new overload wins over a clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarm_ff <= 1'b0;
    end else begin
      alarm_ff <= overload_in | (alarm_ff & ~alarm_clr);
    end
  end

  // Software control and register selection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_ff <= fpac_pkg::CTRL_RST;
      sel_ff  <= fpac_pkg::REG_FIRST;
    end else if (apb_wr && hit_ctrl) begin
      ctrl_ff <= pwdata[1:0];
    end else if (apb_wr && hit_sel) begin
      sel_ff <= pwdata[7:0];
    end
  end

  // Display contents by mode
  logic [15:0] nxt_disp;
  logic [4:0]  nxt_icons;              // Dashes, pct, num, circle, mode
  always_comb begin
    nxt_disp  = 16'h0;
    nxt_icons = 5'h0;
    unique case (mode_ff)
      fpac_pkg::FPAC_AMP: begin
        nxt_disp  = ext_on ? 16'h0 : {8'h0, amp_ff};
        nxt_icons = {ext_on, 1'b1, 3'h0};
      end
      fpac_pkg::FPAC_WELD: begin
        nxt_disp  = weld_val;
        nxt_icons = 5'h01;
      end
      fpac_pkg::FPAC_BROWSE: begin
        nxt_disp  = {8'h0, reg_num_ff};
        nxt_icons = 5'h04;
      end
      fpac_pkg::FPAC_EDIT: begin
        nxt_disp  = edit_val_ff;
        nxt_icons = 5'h02;
      end
      default: begin
        nxt_disp  = 16'h0;
        nxt_icons = 5'h0;
      end
    endcase
  end

  // External amplitude source
  wire [7:0] ana_sel = ctrl_ff[fpac_pkg::CTRL_ANASEL_BIT] ? ana_in_b : ana_in_a;
  wire [7:0] nxt_amp = ext_on ? ana_sel : amp_ff;

  // Registered display and user I/O outputs
  logic [15:0] disp_ff;
  logic [4:0]  icons_ff;
  logic [7:0]  amp_out_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      disp_ff    <= 16'h0;
      icons_ff   <= 5'h0;
      amp_out_ff <= 8'h0;
    end else begin
      disp_ff    <= nxt_disp;
      icons_ff   <= nxt_icons;
      amp_out_ff <= nxt_amp;
    end
  end
  assign disp_value   = disp_ff;
  assign disp_dashes  = icons_ff[4];
  assign icon_pct     = icons_ff[3];
  assign icon_num     = icons_ff[2];
  assign icon_circle  = icons_ff[1];
  assign icon_mode    = icons_ff[0];
  assign icon_alarm   = alarm_ff;
  assign alarm_out    = alarm_ff;
  assign amp_setpoint = amp_out_ff;

  // APB read data, captured in the setup cycle
  logic [31:0] nxt_rd;
  logic [31:0] prdata_ff;
  always_comb begin
    nxt_rd = 32'h0;
    if (hit_ctrl) nxt_rd = {30'h0, ctrl_ff};
    if (hit_stat) nxt_rd = {26'h0, alarm_ff, ext_on, mode_ff};
    if (hit_amp)  nxt_rd = {24'h0, amp_ff};
    if (hit_sel)  nxt_rd = {24'h0, sel_ff};
    if (hit_data) nxt_rd = sel_ok ? {16'h0, cfg_mem[sel_idx]} : 32'h0;
    if (hit_disp) nxt_rd = {11'h0, icons_ff, disp_ff};
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_ff <= 32'h0;
    end else if (psel && !penable) begin
      prdata_ff <= nxt_rd;
    end
  end
  assign prdata  = prdata_ff;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

endmodule
`default_nettype wire

// file: verilog/placeholder_none.sv
// Intentionally empty: all logic lives in fpac_top.
`default_nettype none
`default_nettype wire

// file: bench/fpac_assertions.sv
// Checker for the front-panel block: alarm, display and APB relations.
// Assumes it is bound to fpac_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module fpac_assertions (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // APB
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // User I/O and keys
  input wire logic       overload_in,
  input wire logic       key_rst,
  input wire logic       ext_reset_in,
  input wire logic       start_in,
  input wire logic [7:0] ana_in_a,
  input wire logic [7:0] ana_in_b,
  input wire logic       alarm_out,
  input wire logic [7:0] amp_setpoint,
  // Display
  input wire logic       disp_dashes,
  input wire logic       icon_num,
  input wire logic       icon_circle,
  input wire logic       icon_alarm
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [3:0] quiet_ff;   // Cycles without bus access or dashes
  logic [3:0] since_ff;   // Cycles since a clearing action
  logic       start_ff;   // Start line one cycle back
  logic [3:0] nxt_quiet;
  logic [3:0] nxt_since;
  assign nxt_quiet = (psel || disp_dashes) ? 4'h0 : quiet_ff + 4'(quiet_ff != 4'hf);
  assign nxt_since = (key_rst || ext_reset_in || start_in != start_ff) ? 4'h0
                   : since_ff + 4'(since_ff != 4'hf);
  // Helper counters; reset clears quiet_ff and start_ff and sets since_ff to 4'hf
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      quiet_ff <= 4'h0;
      since_ff <= 4'hf;
      start_ff <= 1'b0;
    end else begin
      quiet_ff <= nxt_quiet;
      since_ff <= nxt_since;
      start_ff <= start_in;
    end
  end
  AST_ALARM_SET: assert property (overload_in |=> alarm_out)
    else $error("alarm not raised by overload");
  AST_ALARM_ICON: assert property (icon_alarm == alarm_out)
    else $error("alarm icon differs from alarm line");
  AST_ALARM_CLEAR: assert property ($fell(alarm_out) |-> since_ff < 4'h6)
    else $error("alarm cleared without a clearing action");
  AST_EXT_SRC: assert property (($stable(ana_in_a) && $stable(ana_in_b) && disp_dashes) [*3]
    |-> amp_setpoint == ana_in_a || amp_setpoint == ana_in_b)
    else $error("external setpoint not from an analog input");
  AST_DASH_MODE: assert property (disp_dashes |-> !icon_num && !icon_circle)
    else $error("dashes outside amplitude view");
  AST_ICON_EXCL: assert property ($onehot0({icon_num, icon_circle, disp_dashes}))
    else $error("mode icons overlap");
  AST_AMP_STEP: assert property (quiet_ff > 4'h3 && $changed(amp_setpoint)
    |-> 8'(amp_setpoint - $past(amp_setpoint)) <= 8'h05
     || 8'($past(amp_setpoint) - amp_setpoint) <= 8'h05)
    else $error("setpoint jumped by more than a coarse step");
  AST_AMP_RANGE: assert property (quiet_ff > 4'h3 |-> amp_setpoint inside {[8'h0a:8'h64]})
    else $error("setpoint outside its limits");
  AST_PREADY: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_SLVERR: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  cover property ($fell(alarm_out));
  cover property (disp_dashes [*3]);
  cover property ($rose(icon_circle));
endmodule
bind fpac_top fpac_assertions u_fpac_assertions (
  .clock, .rst, .psel, .penable, .pready, .pslverr, .overload_in, .key_rst,
  .ext_reset_in, .start_in, .ana_in_a, .ana_in_b, .alarm_out, .amp_setpoint,
  .disp_dashes, .icon_num, .icon_circle, .icon_alarm
);
`default_nettype wire

// file: bench/fpac_panel_model.sv
// Operator keypad and user I/O lines facing the front-panel block.
// Assumes callers enter its tasks from the bench clock domain.
`timescale 1ns/1ns
`default_nettype none
module fpac_panel_model (
  // Clock
  input  wire logic       clock,
  // Keys, high while pressed
  output logic            key_up,
  output logic            key_down,
  output logic            key_cfg,
  output logic            key_rst,
  // User I/O lines
  output logic            ext_reset_in,
  output logic            start_in,
  output logic            overload_in,
  output logic      [7:0] ana_in_a,
  output logic      [7:0] ana_in_b
);
  logic [3:0] key_ff;  // Pressed keys: up, down, cfg, reset
  assign key_up   = key_ff[0];
  assign key_down = key_ff[1];
  assign key_cfg  = key_ff[2];
  assign key_rst  = key_ff[3];
  assign ana_in_a = 8'h37;  // Steady analog levels, distinct from each other
  assign ana_in_b = 8'h4b;
  // Idle: no key, start applied
  initial begin
    key_ff = 4'h0;
    ext_reset_in = 1'b0;
    start_in = 1'b1;
    overload_in = 1'b0;
  end
  // Set one key level just after an edge
  task automatic press(input int k, input logic lvl);
    @(posedge clock);
    key_ff[k] <= lvl;
  endtask
  // Press and release, long enough for the synchroniser
  task automatic tap(input int k);
    press(k, 1'b1);
    repeat (5) @(posedge clock);
    press(k, 1'b0);
    repeat (8) @(posedge clock);
  endtask
  // One-cycle overload event
  task automatic pulse_overload();
    @(posedge clock);
    overload_in <= 1'b1;
    @(posedge clock);
    overload_in <= 1'b0;
  endtask
  // External reset held for several cycles
  task automatic ext_reset();
    @(posedge clock);
    ext_reset_in <= 1'b1;
    repeat (6) @(posedge clock);
    ext_reset_in <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  // Remove and re-apply the start signal
  task automatic restart();
    @(posedge clock);
    start_in <= 1'b0;
    repeat (6) @(posedge clock);
    start_in <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// Bench for the front-panel block: APB master and panel scenarios.
// Assumes short repeat and hold counts; the panel model drives keys and I/O.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clock;
  logic        rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err;
  logic        key_up, key_down, key_cfg, key_rst, ext_reset_in, start_in, overload_in;
  logic [7:0]  ana_in_a, ana_in_b, amp_setpoint;
  logic        alarm_out, disp_dashes, icon_pct, icon_num, icon_circle, icon_alarm, icon_mode;
  logic [15:0] disp_value, keep_val;
  int          failures, compares, idx;
  fpac_top #(.REPEAT_CYC(20), .HOLD_CYC(100)) u_fpac_top (
    .clock, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .key_up, .key_down, .key_cfg, .key_rst, .ext_reset_in, .start_in, .overload_in,
    .ana_in_a, .ana_in_b, .alarm_out, .amp_setpoint, .disp_value, .disp_dashes,
    .icon_pct, .icon_num, .icon_circle, .icon_alarm, .icon_mode);
  fpac_panel_model u_fpac_panel_model (
    .clock, .key_up, .key_down, .key_cfg, .key_rst, .ext_reset_in, .start_in,
    .overload_in, .ana_in_a, .ana_in_b);
  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Verdict and end of run
  task automatic print_verdict();
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= addr;
    pwdata <= data;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Write a configuration register through select and data
  task automatic reg_wr(input logic [7:0] num, input logic [15:0] val);
    apb(1'b1, fpac_pkg::OFS_SEL, {24'h0, num});
    apb(1'b1, fpac_pkg::OFS_DATA, {16'h0, val});
    repeat (6) @(posedge clock);
  endtask
  task automatic tap(input int k);
    u_fpac_panel_model.tap(k);
  endtask
  // Hold an arrow; fine steps early, coarse step after the hold time
  task automatic hold_chk(input int k, input bit up);
    logic [15:0] prev, sz;
    prev = disp_value;
    u_fpac_panel_model.press(k, 1'b1);
    while (disp_value === prev) @(posedge clock);
    prev = disp_value;
    repeat (10) @(posedge clock);
    for (int i = 1; i <= 8; i++) begin
      repeat (20) @(posedge clock);
      sz = (i == 8) ? fpac_pkg::STEP_COARSE : fpac_pkg::STEP_FINE;
      if (i <= 3 || i == 8)
        chk("repeat step", 32'(up ? prev + sz : prev - sz), 32'(disp_value));
      prev = disp_value;
    end
    u_fpac_panel_model.press(k, 1'b0);
    repeat (10) @(posedge clock);
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    chk("pct icon", 1, 32'(icon_pct));
    chk("shown amp", 32'(fpac_pkg::AMP_RST), 32'(disp_value));
    chk("mode icon", 0, 32'(icon_mode));
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 1, 32'(err));
    chk("unmapped data", 0, rd);
    tap(1);
    chk("amp down", 32'(fpac_pkg::AMP_RST) - 1, 32'(disp_value));
    tap(0);
    tap(0);
    chk("amp clamp", 32'(fpac_pkg::AMP_MAX), 32'(disp_value));
    hold_chk(1, 1'b0);
    keep_val = disp_value;
    tap(1);
    chk("amp after hold", 32'(keep_val) - 1, 32'(disp_value));
    // External amplitude control
    reg_wr(fpac_pkg::REG_EXTAMP, 16'h1);
    chk("dashes", 1, 32'(disp_dashes));
    chk("analog a", 32'h37, 32'(amp_setpoint));
    apb(1'b1, fpac_pkg::OFS_CTRL, 32'h3);
    repeat (4) @(posedge clock);
    chk("analog b", 32'h4b, 32'(amp_setpoint));
    apb(1'b0, fpac_pkg::OFS_AMP, 32'h0);
    keep_val = rd[15:0];
    tap(0);
    apb(1'b0, fpac_pkg::OFS_AMP, 32'h0);
    chk("amp frozen", 32'(keep_val), rd);
    reg_wr(fpac_pkg::REG_EXTAMP, 16'h0);
    apb(1'b1, fpac_pkg::OFS_CTRL, 32'h1);
    // Alarm with reset required
    u_fpac_panel_model.pulse_overload();
    repeat (2) @(posedge clock);
    chk("alarm set", 1, 32'(alarm_out));
    chk("alarm icon", 1, 32'(icon_alarm));
    u_fpac_panel_model.restart();
    chk("alarm kept", 1, 32'(alarm_out));
    tap(3);
    chk("alarm key clear", 0, 32'(alarm_out));
    u_fpac_panel_model.pulse_overload();
    u_fpac_panel_model.ext_reset();
    chk("alarm ext clear", 0, 32'(alarm_out));
    // Alarm with no reset required
    apb(1'b1, fpac_pkg::OFS_CTRL, 32'h0);
    u_fpac_panel_model.pulse_overload();
    tap(3);
    chk("alarm kept", 1, 32'(alarm_out));
    u_fpac_panel_model.restart();
    chk("alarm start clear", 0, 32'(alarm_out));
    apb(1'b1, fpac_pkg::OFS_CTRL, 32'h1);
    // Register browse and edit
    tap(2);
    chk("num icon", 1, 32'(icon_num));
    chk("first reg", 32'(fpac_pkg::REG_FIRST), 32'(disp_value));
    tap(0);
    chk("next reg", 32'(fpac_pkg::REG_FIRST) + 1, 32'(disp_value));
    tap(1);
    chk("prev reg", 32'(fpac_pkg::REG_FIRST), 32'(disp_value));
    tap(0);
    tap(2);
    chk("circle icon", 1, 32'(icon_circle));
    chk("edit value", 0, 32'(disp_value));
    tap(0);
    chk("edit up", 1, 32'(disp_value));
    tap(0);
    chk("edit clamp", 1, 32'(disp_value));
    tap(3);
    chk("edit default", 0, 32'(disp_value));
    tap(2);
    chk("commit view", 1, 32'(icon_pct));
    tap(2);
    for (idx = 0; idx < 8 && disp_value !== 16'h0069; idx++) tap(0);
    tap(2);
    chk("edit 105", 32'h50, 32'(disp_value));
    hold_chk(0, 1'b1);
    keep_val = disp_value;
    tap(2);
    chk("commit view", 1, 32'(icon_pct));
    apb(1'b1, fpac_pkg::OFS_SEL, 32'h69);
    apb(1'b0, fpac_pkg::OFS_DATA, 32'h0);
    chk("stored value", 32'(keep_val), rd);
    // Commit in a weld mode shows that mode
    reg_wr(fpac_pkg::REG_WELDMODE, 16'h2);
    repeat (3) tap(2);
    chk("weld icon", 1, 32'(icon_mode));
    chk("weld shown", 2, 32'(disp_value));
    tap(2);
    chk("back to amp", 1, 32'(icon_pct));
    print_verdict();
  end
endmodule
`default_nettype wire
